// file: hdl/spf_front_end.v
// Serial flash front end: pin framing, shifting, status, protection, array requests
`timescale 1ns/1ps
`include "spf_regs.vh"

module spf_front_end #(
  parameter T_PP_CYC = `SPF_T_PP_NS / `SPF_CLK_NS,
  parameter T_SE_CYC = `SPF_T_SE_NS / `SPF_CLK_NS,
  parameter T_BE_CYC = `SPF_T_BE_NS / `SPF_CLK_NS,
  parameter T_CE_CYC = `SPF_T_CE_NS / `SPF_CLK_NS,
  parameter T_W_CYC  = `SPF_T_W_NS / `SPF_CLK_NS
) (
  input  wire        clk_in,
  input  wire        reset_in,
  input  wire        sck_in,
  input  wire        select_n_in,
  input  wire        serial_in,
  input  wire        pause_n_in,
  input  wire        write_guard_n_in,
  output reg         serial_out,
  output reg         serial_out_en_out,
  output wire        arr_valid_out,
  input  wire        arr_ready_in,
  output wire [2:0]  arr_op_out,
  output wire [17:0] arr_addr_out,
  output wire [7:0]  arr_data_out,
  input  wire        arr_rvalid_in,
  input  wire [7:0]  arr_rdata_in,
  output reg         busy_flag_out,
  output reg         write_latch_out,
  output reg  [2:0]  block_protect_out,
  output reg         status_write_lock_out,
  output reg         otp_lock_out,
  output reg         overrun_out
);

  // ------------------------------------------------------------
  // Frame states
  // ------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_CMD  = 5'b00010;
  localparam [4:0] ST_ADDR = 5'b00100;
  localparam [4:0] ST_DATA = 5'b01000;
  localparam [4:0] ST_IGN  = 5'b10000;

  wire [4:0]  pins_s;
  reg         sck_prev;
  reg         cs_prev;
  reg         frame;
  reg  [4:0]  state;
  reg  [2:0]  bit_cnt;
  reg  [6:0]  rx_sh;
  reg  [7:0]  cmd;
  reg  [23:0] addr;
  reg  [1:0]  addr_cnt;
  reg         addr_done;
  reg  [8:0]  prog_cnt;
  reg  [7:0]  sr_new;
  reg         sr_got;
  reg  [7:0]  tx_sh;
  reg  [7:0]  rdata;
  reg  [31:0] busy_cnt;
  reg         push_valid;
  reg  [28:0] push_word;
  reg         ev_push;
  reg  [28:0] ev_word;
  reg  [31:0] next_busy;
  reg         ev_busy;
  wire        buf_ready;

  // Pin order: {sck, select_n, serial_in, pause_n, write_guard_n}
  spf_sync #(.W(5)) u_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .async_in ({sck_in, select_n_in, serial_in, pause_n_in, write_guard_n_in}),
    .sync_out (pins_s)
  );

  wire s_sck   = pins_s[4];
  wire s_cs_n  = pins_s[3];
  wire s_din   = pins_s[2];
  wire s_pause = pins_s[1];
  wire s_wg_n  = pins_s[0];

  // ------------------------------------------------------------
  // Edge finding on the sampled link clock and select
  // ------------------------------------------------------------
  wire cs_fall   = cs_prev & ~s_cs_n;
  wire cs_rise   = ~cs_prev & s_cs_n;
  wire live      = frame & ~s_cs_n & s_pause;
  wire rx_edge   = live & s_sck & ~sck_prev;
  wire tx_edge   = live & ~s_sck & sck_prev;
  wire byte_done = rx_edge & (bit_cnt == 3'd7);
  wire [7:0]  new_byte  = {rx_sh, s_din};
  wire [23:0] addr_last = {addr[15:0], new_byte};
  wire        busy      = (busy_cnt != 32'h0000_0000);
  // Any nonzero low protect pair guards the whole array; coarse but safe
  wire        prot      = (block_protect_out[1:0] != 2'b00);
  wire        write_latch       = write_latch_out;
  wire        whole     = (bit_cnt == 3'd0);
  wire [7:0]  status    = {status_write_lock_out, 2'b00, block_protect_out, write_latch, busy};

  // ------------------------------------------------------------
  // Array request and busy time for this cycle's event
  // ------------------------------------------------------------
  always @* begin
    ev_push   = 1'b0;
    ev_word   = {`SPF_ARR_READ, addr[17:0], 8'h00};
    ev_busy   = 1'b0;
    next_busy = 32'h0000_0000;
    if (byte_done && state == ST_ADDR && addr_cnt == 2'd2) begin
      if (cmd == `SPF_OP_READ) begin
        ev_push = 1'b1;
        ev_word = {`SPF_ARR_READ, addr_last[17:0], 8'h00};
      end else if (cmd == `SPF_OP_SEC_READ) begin
        ev_push = 1'b1;
        ev_word = {`SPF_ARR_SEC_READ, 10'h000, addr_last[7:0], 8'h00};
      end
    end else if (byte_done && state == ST_DATA) begin
      if (cmd == `SPF_OP_READ) begin
        ev_push = 1'b1;
        ev_word = {`SPF_ARR_READ, addr[17:0] + 18'h0_0001, 8'h00};
      end else if (cmd == `SPF_OP_SEC_READ) begin
        ev_push = 1'b1;
        ev_word = {`SPF_ARR_SEC_READ, 10'h000, addr[7:0] + 8'h01, 8'h00};
      end else if (cmd == `SPF_OP_PAGE_WRITE_CMD && write_latch && !prot) begin
        ev_push = 1'b1;
        ev_word = {`SPF_ARR_PROG, addr[17:0], new_byte};
      end else if (cmd == `SPF_OP_SEC_PROGRAM && write_latch && !otp_lock_out) begin
        ev_push = 1'b1;
        ev_word = {`SPF_ARR_SEC_PROG, 10'h000, addr[7:0], new_byte};
      end
    end else if (cs_rise && frame && whole && write_latch && !busy) begin
      // Erase and program cycles start only when the frame closes on a byte
      if (cmd == `SPF_OP_SECTOR_ERASE && addr_done && !prot) begin
        ev_push   = 1'b1;
        ev_word   = {`SPF_ARR_SECTOR_ERASE, addr[17:12], 12'h000, 8'hFF};
        ev_busy   = 1'b1;
        next_busy = T_SE_CYC;
      end else if (cmd == `SPF_OP_BLOCK_ERASE && addr_done && !prot) begin
        ev_push   = 1'b1;
        ev_word   = {`SPF_ARR_BLOCK_ERASE, addr[17:16], 16'h0000, 8'hFF};
        ev_busy   = 1'b1;
        next_busy = T_BE_CYC;
      end else if (cmd == `SPF_OP_CHIP_ERASE && !prot) begin
        ev_push   = 1'b1;
        ev_word   = {`SPF_ARR_CHIP_ERASE, 18'h0_0000, 8'hFF};
        ev_busy   = 1'b1;
        next_busy = T_CE_CYC;
      end else if ((cmd == `SPF_OP_PAGE_WRITE_CMD || cmd == `SPF_OP_SEC_PROGRAM) &&
                   prog_cnt != 9'h000) begin
        ev_busy   = 1'b1;
        next_busy = T_PP_CYC;
      end else if (cmd == `SPF_OP_WRITE_STATUS && sr_got && s_wg_n) begin
        ev_busy   = 1'b1;
        next_busy = T_W_CYC;
      end
    end
  end

  // ------------------------------------------------------------
  // Frame control, receive shifter, command decode
  // ------------------------------------------------------------
  always @(posedge clk_in) begin
    if (reset_in) begin
      sck_prev  <= 1'b0;
      cs_prev   <= 1'b0;     // Treated as low so a rise must come first
      frame     <= 1'b0;
      state     <= ST_IDLE;
      bit_cnt   <= 3'd0;
      rx_sh     <= 7'h00;
      cmd       <= 8'h00;
      addr      <= 24'h00_0000;
      addr_cnt  <= 2'd0;
      addr_done <= 1'b0;
      prog_cnt  <= 9'h000;
      sr_new    <= 8'h00;
      sr_got    <= 1'b0;
    end else begin
      sck_prev <= s_sck;
      cs_prev  <= s_cs_n;
      if (cs_fall) begin
        frame     <= 1'b1;
        state     <= ST_CMD;
        bit_cnt   <= 3'd0;
        addr_cnt  <= 2'd0;
        addr_done <= 1'b0;
        prog_cnt  <= 9'h000;
        sr_got    <= 1'b0;
      end else if (cs_rise) begin
        frame <= 1'b0;
        state <= ST_IDLE;
      end else if (rx_edge) begin
        bit_cnt <= bit_cnt + 3'd1;
        rx_sh   <= new_byte[6:0];
        if (bit_cnt == 3'd7) begin
          case (state)
            ST_CMD: begin
              cmd <= new_byte;
              if (busy && new_byte != `SPF_OP_READ_STATUS)
                state <= ST_IGN;
              else if (new_byte == `SPF_OP_READ_STATUS || new_byte == `SPF_OP_WRITE_STATUS)
                state <= ST_DATA;
              else if (new_byte == `SPF_OP_READ || new_byte == `SPF_OP_PAGE_WRITE_CMD ||
                       new_byte == `SPF_OP_SECTOR_ERASE || new_byte == `SPF_OP_BLOCK_ERASE ||
                       new_byte == `SPF_OP_SEC_PROGRAM || new_byte == `SPF_OP_SEC_READ)
                state <= ST_ADDR;
              else
                state <= ST_IGN;
            end
            ST_ADDR: begin
              addr     <= addr_last;
              addr_cnt <= addr_cnt + 2'd1;
              if (addr_cnt == 2'd2) begin
                addr_done <= 1'b1;
                state     <= (cmd == `SPF_OP_SECTOR_ERASE || cmd == `SPF_OP_BLOCK_ERASE) ?
                             ST_IGN : ST_DATA;
              end
            end
            ST_DATA: begin
              if (cmd == `SPF_OP_WRITE_STATUS) begin
                sr_new <= new_byte;
                sr_got <= 1'b1;
                state  <= ST_IGN;
              end else if (cmd == `SPF_OP_READ) begin
                addr <= addr + 24'h00_0001;
              end else if (cmd != `SPF_OP_READ_STATUS) begin
                // Column wraps inside the page; page bits never move
                addr[7:0] <= addr[7:0] + 8'h01;
                if (prog_cnt != 9'h100)
                  prog_cnt <= prog_cnt + 9'h001;
              end
            end
            default: state <= state;
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Status bits, write latch and busy timer
  // ------------------------------------------------------------
  always @(posedge clk_in) begin
    if (reset_in) begin
      busy_cnt              <= 32'h0000_0000;
      busy_flag_out         <= 1'b0;
      write_latch_out       <= 1'b0;
      block_protect_out     <= `SPF_BP_RESET;
      status_write_lock_out <= `SPF_LOCK_RESET;
      otp_lock_out          <= 1'b0;
    end else begin
      busy_flag_out <= busy | ev_busy;
      if (ev_busy)
        busy_cnt <= next_busy;
      else if (busy)
        busy_cnt <= busy_cnt - 32'h0000_0001;
      if (byte_done && state == ST_CMD && !busy) begin
        if (new_byte == `SPF_OP_WRITE_UNLOCK)
          write_latch_out <= 1'b1;
        else if (new_byte == `SPF_OP_WRITE_LOCK_CMD)
          write_latch_out <= 1'b0;
        else if (new_byte == `SPF_OP_SEC_LOCK && write_latch) begin
          otp_lock_out    <= 1'b1;
          write_latch_out <= 1'b0;
        end
      end
      if (cs_rise && frame && whole && write_latch && !busy) begin
        if (cmd == `SPF_OP_WRITE_STATUS && sr_got && s_wg_n) begin
          block_protect_out     <= sr_new[`SPF_SR_BP_HI:`SPF_SR_BP_LO];
          status_write_lock_out <= sr_new[`SPF_SR_LOCK];
        end
        if (ev_busy)
          write_latch_out <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Transmit shifter; loads a whole byte at each byte boundary
  // ------------------------------------------------------------
  always @(posedge clk_in) begin
    if (reset_in) begin
      tx_sh             <= 8'h00;
      serial_out        <= 1'b0;
      serial_out_en_out <= 1'b0;
      rdata             <= 8'h00;
    end else begin
      serial_out_en_out <= live & (state == ST_DATA) & (cmd != `SPF_OP_WRITE_STATUS);
      if (arr_rvalid_in)
        rdata <= arr_rdata_in;
      if (tx_edge) begin
        if (whole && state == ST_DATA) begin
          serial_out <= (cmd == `SPF_OP_READ_STATUS) ? status[7] : rdata[7];
          tx_sh      <= (cmd == `SPF_OP_READ_STATUS) ? {status[6:0], 1'b0} :
                        {rdata[6:0], 1'b0};
        end else begin
          serial_out <= tx_sh[7];
          tx_sh      <= {tx_sh[6:0], 1'b0};
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Request staging; a word the buffer cannot take is flagged
  // ------------------------------------------------------------
  always @(posedge clk_in) begin
    if (reset_in) begin
      push_valid  <= 1'b0;
      push_word   <= 29'h0000_0000;
      overrun_out <= 1'b0;
    end else begin
      if (push_valid && buf_ready)
        push_valid <= 1'b0;
      if (ev_push) begin
        push_valid <= 1'b1;
        push_word  <= ev_word;
        if (push_valid && !buf_ready)
          overrun_out <= 1'b1;
      end
    end
  end

  spf_buf #(.W(29)) u_buf (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .in_valid_in   (push_valid),
    .in_ready_out  (buf_ready),
    .in_data_in    (push_word),
    .out_valid_out (arr_valid_out),
    .out_ready_in  (arr_ready_in),
    .out_data_out  ({arr_op_out, arr_addr_out, arr_data_out})
  );

endmodule

// file: hdl/spf_regs.vh
// Constants shared by the serial flash front end: opcodes, status layout, timing
`ifndef SPF_REGS_VH
`define SPF_REGS_VH

// ------------------------------------------------------------
// Instruction opcodes
// ------------------------------------------------------------
`define SPF_OP_WRITE_STATUS    8'h01
`define SPF_OP_PAGE_WRITE_CMD  8'h02
`define SPF_OP_READ            8'h03
`define SPF_OP_WRITE_LOCK_CMD  8'h04
`define SPF_OP_READ_STATUS     8'h05
`define SPF_OP_WRITE_UNLOCK    8'h06
`define SPF_OP_SECTOR_ERASE    8'h20
`define SPF_OP_SEC_PROGRAM     8'h42
`define SPF_OP_SEC_READ        8'h48
`define SPF_OP_SEC_LOCK        8'h4A
`define SPF_OP_CHIP_ERASE      8'hC7
`define SPF_OP_BLOCK_ERASE     8'hD8

// ------------------------------------------------------------
// Status byte field positions and reset values
// ------------------------------------------------------------
`define SPF_SR_BUSY            0
`define SPF_SR_LATCH           1
`define SPF_SR_BP_LO           2
`define SPF_SR_BP_HI           4
`define SPF_SR_LOCK            7
`define SPF_BP_RESET           3'h7
`define SPF_LOCK_RESET         1'b0

// ------------------------------------------------------------
// Array organisation
// ------------------------------------------------------------
`define SPF_ADDR_W             18
`define SPF_ARRAY_BYTES        262144
`define SPF_PAGE_BYTES         256
`define SPF_SECTOR_BYTES       4096
`define SPF_BLOCK_BYTES        65536

// ------------------------------------------------------------
// Array request operations
// ------------------------------------------------------------
`define SPF_ARR_READ           3'h0
`define SPF_ARR_PROG           3'h1
`define SPF_ARR_SECTOR_ERASE   3'h2
`define SPF_ARR_BLOCK_ERASE    3'h3
`define SPF_ARR_CHIP_ERASE     3'h4
`define SPF_ARR_SEC_READ       3'h5
`define SPF_ARR_SEC_PROG       3'h6

// ------------------------------------------------------------
// Internal cycle times in ns and the clock period
// ------------------------------------------------------------
`define SPF_CLK_NS             4
`define SPF_T_PP_NS            1500000
`define SPF_T_SE_NS            90000000
`define SPF_T_BE_NS            500000000
`define SPF_T_CE_NS            2000000000
`define SPF_T_W_NS             10000000

`endif

// file: hdl/spf_sync.v
// Two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps

module spf_sync #(
  parameter W = 5
) (
  input  wire         clk_in,
  input  wire         reset_in,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;

  // ------------------------------------------------------------
  // Per-bit synchroniser; stage1 is read only by stage2
  // ------------------------------------------------------------
  // Reset low: a select held low since power-up must not show a false fall
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk_in) begin
        if (reset_in) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage2;

endmodule

// file: hdl/spf_buf.v
// Two-entry valid/ready buffer with registered outputs
`timescale 1ns/1ps

module spf_buf #(
  parameter W = 29
) (
  input  wire         clk_in,
  input  wire         reset_in,
  input  wire         in_valid_in,
  output wire         in_ready_out,
  input  wire [W-1:0] in_data_in,
  output wire         out_valid_out,
  input  wire         out_ready_in,
  output wire [W-1:0] out_data_out
);

  reg [W-1:0] head;
  reg         head_v;
  reg [W-1:0] tail;
  reg         tail_v;

  wire pop  = head_v & out_ready_in;
  wire push = in_valid_in & ~tail_v;

  // ------------------------------------------------------------
  // Head feeds the outputs straight from flops; tail absorbs a stall
  // ------------------------------------------------------------
  always @(posedge clk_in) begin
    if (reset_in) begin
      head   <= {W{1'b0}};
      head_v <= 1'b0;
      tail   <= {W{1'b0}};
      tail_v <= 1'b0;
    end else if (!head_v || pop) begin
      if (tail_v) begin
        head   <= tail;
        head_v <= 1'b1;
        tail_v <= 1'b0;
      end else if (push) begin
        head   <= in_data_in;
        head_v <= 1'b1;
      end else begin
        head_v <= 1'b0;
      end
    end else if (push) begin
      tail   <= in_data_in;
      tail_v <= 1'b1;
    end
  end

  assign in_ready_out  = ~tail_v;
  assign out_valid_out = head_v;
  assign out_data_out  = head;

endmodule

// file: tb/spf_array_model.sv
// Far-side array model: byte store, erases, security sector, read answers
`timescale 1ns/1ps
`include "spf_regs.vh"

module spf_array_model (
  input  wire        clk_in,
  input  wire        reset_in,
  input  wire        slow_in,
  input  wire        valid_in,
  output wire        ready_out,
  input  wire [2:0]  op_in,
  input  wire [17:0] addr_in,
  input  wire [7:0]  data_in,
  output reg         rvalid_out,
  output reg  [7:0]  rdata_out
);
  // ----------------------------------------
  // Storage: absent bytes read as erased
  // ----------------------------------------
  bit [7:0] mem [int];
  bit [7:0] sec [int];
  reg [1:0] cnt;

  // Slow mode takes one word in four, so the buffer must hold back-pressure
  assign ready_out = !slow_in || (cnt == 2'h3);

  function automatic [7:0] peek(input int a);
    peek = mem.exists(a) ? mem[a] : 8'hff;
  endfunction

  // One request per accepted cycle; read answer one clock later
  always @(posedge clk_in) begin
    cnt <= cnt + 2'h1;
    rvalid_out <= 1'b0;
    rdata_out <= ~rdata_out; // Idle data keeps moving so nothing stale passes
    if (reset_in) begin
      cnt <= 2'h0;
      rdata_out <= 8'h00;
    end else if (valid_in && ready_out) begin
      case (op_in)
        `SPF_ARR_READ: begin
          rvalid_out <= 1'b1;
          rdata_out <= peek(addr_in);
        end
        `SPF_ARR_PROG: mem[addr_in] = peek(addr_in) & data_in;
        `SPF_ARR_SECTOR_ERASE: for (int i = 0; i < `SPF_SECTOR_BYTES; i++) mem.delete(addr_in + i);
        `SPF_ARR_BLOCK_ERASE: for (int i = 0; i < `SPF_BLOCK_BYTES; i++) mem.delete(addr_in + i);
        `SPF_ARR_CHIP_ERASE: mem.delete();
        `SPF_ARR_SEC_READ: begin
          rvalid_out <= 1'b1;
          rdata_out <= sec.exists(addr_in[7:0]) ? sec[addr_in[7:0]] : 8'hff;
        end
        `SPF_ARR_SEC_PROG: sec[addr_in[7:0]] = data_in;
        default: ;
      endcase
    end
  end
endmodule

// file: tb/spf_front_end_checker.sv
// Concurrent checks on the serial flash front end ports
`timescale 1ns/1ps
`include "spf_regs.vh"

module spf_front_end_checker (
  input wire        clk_in,
  input wire        reset_in,
  input wire        sck_in,
  input wire        select_n_in,
  input wire        serial_in,
  input wire        pause_n_in,
  input wire        write_guard_n_in,
  input wire        serial_out,
  input wire        serial_out_en_out,
  input wire        arr_valid_out,
  input wire        arr_ready_in,
  input wire [2:0]  arr_op_out,
  input wire [17:0] arr_addr_out,
  input wire [7:0]  arr_data_out,
  input wire        arr_rvalid_in,
  input wire [7:0]  arr_rdata_in,
  input wire        busy_flag_out,
  input wire        write_latch_out,
  input wire [2:0]  block_protect_out,
  input wire        status_write_lock_out,
  input wire        otp_lock_out,
  input wire        overrun_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // ----------------------------------------
  // Pins and flags
  // ----------------------------------------
  AST_RESET_VALUES: assert property ($fell(reset_in) |-> block_protect_out == 3'h7
    && !busy_flag_out && !write_latch_out && !otp_lock_out && !overrun_out) else $error("bad flags after reset");
  AST_DESELECT_FLOAT: assert property (select_n_in [*5] |-> !serial_out_en_out)
    else $error("output driven while deselected");
  AST_PAUSE_FLOAT: assert property (!pause_n_in [*5] |-> !serial_out_en_out)
    else $error("output driven while paused");
  // Output moves 3 to 4 clocks after a pin fall, so the pin was low 2 and 3 clocks back
  AST_OUT_ON_FALL: assert property ($changed(serial_out) && serial_out_en_out && $past(serial_out_en_out)
    |-> !$past(sck_in, 2) && !$past(sck_in, 3)) else $error("output changed off a clock fall");
  AST_GUARD_HOLD: assert property (!write_guard_n_in [*4] |=> $stable(block_protect_out)
    && $stable(status_write_lock_out)) else $error("status changed under write guard");
  AST_BUSY_NEEDS_LATCH: assert property ($rose(busy_flag_out) |-> $past(write_latch_out))
    else $error("busy started without write latch");
  AST_OTP_STICKY: assert property (otp_lock_out |=> otp_lock_out)
    else $error("security lock cleared");

  // ----------------------------------------
  // Array request port
  // ----------------------------------------
  AST_ARR_HOLD: assert property (arr_valid_out && !arr_ready_in |=> arr_valid_out
    && $stable(arr_op_out) && $stable(arr_addr_out) && $stable(arr_data_out)) else $error("request dropped");
  AST_ERASE_ALIGN: assert property (arr_valid_out && arr_op_out == `SPF_ARR_SECTOR_ERASE
    |-> arr_addr_out[11:0] == 12'h000 && arr_data_out == 8'hff) else $error("sector erase misaligned");

  COV_READ: cover property (arr_valid_out && arr_ready_in && arr_op_out == `SPF_ARR_READ);
  COV_BUSY: cover property ($rose(busy_flag_out));
  COV_DRIVE: cover property ($rose(serial_out_en_out));
endmodule

// file: tb/spf_front_end_tb_top.sv
// Testbench: host serial driver, status and array content checks
`timescale 1ns/1ps
`include "spf_regs.vh"

module spf_front_end_tb_top;
  reg clk_in = 1'b0, reset_in, sck_in, select_n_in, serial_in;
  reg pause_n_in, write_guard_n_in, slow, mode3, do_pause;
  wire serial_out, serial_out_en_out, arr_valid_out, arr_ready_in, arr_rvalid_in, busy_flag_out;
  wire write_latch_out, status_write_lock_out, otp_lock_out, overrun_out;
  wire [2:0] arr_op_out, block_protect_out;
  wire [17:0] arr_addr_out;
  wire [7:0] arr_data_out, arr_rdata_in;
  int fails = 0, checked = 0, cyc = 0;
  logic [7:0] rx[$];

  spf_front_end #(.T_PP_CYC(20), .T_SE_CYC(30), .T_BE_CYC(40), .T_CE_CYC(50), .T_W_CYC(10)) uut (
    .clk_in, .reset_in, .sck_in, .select_n_in, .serial_in, .pause_n_in, .write_guard_n_in,
    .serial_out, .serial_out_en_out, .arr_valid_out, .arr_ready_in, .arr_op_out, .arr_addr_out,
    .arr_data_out, .arr_rvalid_in, .arr_rdata_in, .busy_flag_out, .write_latch_out,
    .block_protect_out, .status_write_lock_out, .otp_lock_out, .overrun_out);
  spf_array_model model (.clk_in(clk_in), .reset_in(reset_in), .slow_in(slow),
    .valid_in(arr_valid_out), .ready_out(arr_ready_in), .op_in(arr_op_out),
    .addr_in(arr_addr_out), .data_in(arr_data_out), .rvalid_out(arr_rvalid_in),
    .rdata_out(arr_rdata_in));

  always #2 clk_in = ~clk_in;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task check(input [31:0] seen, input [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task conclude;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One byte, MSB first; each clock level lasts 4 cycles, 32 ns a bit
  task xbyte(input [7:0] tx);
    logic [7:0] r;
    for (int i = 7; i >= 0; i--) begin
      sck_in <= 1'b0;
      serial_in <= tx[i];
      tick(4);
      // Pause mid-byte and wiggle the pins: the device must not count them
      if (do_pause && i == 3) begin
        pause_n_in <= 1'b0;
        serial_in <= ~tx[i];
        tick(6);
        sck_in <= 1'b1;
        tick(4);
        sck_in <= 1'b0;
        tick(4);
        @(negedge clk_in) check(serial_out_en_out, 0, "paused enable");
        @(posedge clk_in) pause_n_in <= 1'b1;
        serial_in <= tx[i];
        tick(6);
      end
      sck_in <= 1'b1;
      tick(3);
      // A floated output reads as the inverse so it never passes as data
      @(negedge clk_in) r[i] = serial_out_en_out ? serial_out : ~serial_out;
      @(posedge clk_in);
    end
    rx.push_back(r);
  endtask

  task frame(input logic [7:0] b[$]);
    rx.delete();
    select_n_in <= 1'b0;
    tick(4);
    foreach (b[k]) xbyte(b[k]);
    sck_in <= mode3;
    tick(4);
    select_n_in <= 1'b1;
    tick(4);
  endtask

  // Bounded wait for an internal cycle to start and finish
  task wait_done;
    logic seen;
    seen = 1'b0;
    for (int k = 0; k < 400 && !(seen && busy_flag_out === 1'b0); k++) begin
      @(negedge clk_in) seen = seen | busy_flag_out;
    end
    check(seen, 1, "busy seen");
    @(posedge clk_in);
  endtask

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      conclude;
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {reset_in, pause_n_in, write_guard_n_in} = 3'b111;
    {sck_in, select_n_in, serial_in, slow, mode3, do_pause} = 6'h00;
    tick(10);
    reset_in <= 1'b0;
    tick(3);
    // Select low since power-up: this unlock must be ignored
    xbyte(`SPF_OP_WRITE_UNLOCK);
    sck_in <= 1'b0;
    tick(4);
    select_n_in <= 1'b1;
    @(negedge clk_in) check(write_latch_out, 0, "latch before select edge");
    check(block_protect_out, 3'h7, "protect after reset");
    check({otp_lock_out, overrun_out, busy_flag_out, status_write_lock_out}, 0, "flags after reset");
    @(posedge clk_in) $display("test power-up done");
    tick(3);
    frame('{8'h06});
    write_guard_n_in <= 1'b0;
    frame('{8'h01, 8'h00});
    tick(30);
    check(block_protect_out, 3'h7, "guarded status");
    write_guard_n_in <= 1'b1;
    frame('{8'h06});
    check(write_latch_out, 1, "latch set");
    frame('{8'h05, 8'h00});
    check(rx[1], 8'h1e, "status byte");
    frame('{8'h01, 8'h00});
    wait_done;
    check(block_protect_out, 3'h0, "status written");
    $display("test status write done");
    slow <= 1'b1;
    frame('{8'h02, 8'h00, 8'h03, 8'h00, 8'h00});
    tick(40);
    check(model.peek(18'h0_0300), 8'hff, "program without latch");
    frame('{8'h06});
    frame('{8'h02, 8'h00, 8'h01, 8'hfe, 8'ha5, 8'h3c, 8'h0f});
    wait_done;
    check(model.peek(18'h0_01fe), 8'ha5, "program first");
    check(model.peek(18'h0_0100), 8'h0f, "program wrap");
    frame('{8'h06});
    frame('{8'h02, 8'h00, 8'h01, 8'h00, 8'hf5});
    wait_done;
    check(model.peek(18'h0_0100), 8'h05, "program clears only");
    $display("test program done");
    slow <= 1'b0;
    do_pause <= 1'b1;
    frame('{8'h03, 8'h00, 8'h01, 8'hfe, 8'h00, 8'h00, 8'h00});
    do_pause <= 1'b0;
    check(rx[4], 8'ha5, "read byte 0");
    check(rx[5], 8'h3c, "read byte 1");
    check(rx[6], 8'hff, "read past page");
    $display("test paused read done");
    mode3 <= 1'b1;
    sck_in <= 1'b1;
    tick(4);
    frame('{8'h06});
    frame('{8'h20, 8'h00, 8'h01, 8'h23});
    wait_done;
    check(model.peek(18'h0_0100), 8'hff, "sector erased");
    frame('{8'h03, 8'h00, 8'h01, 8'hfe, 8'h00});
    check(rx[4], 8'hff, "mode 3 read");
    frame('{8'h06});
    frame('{8'h4a});
    check(otp_lock_out, 1, "security lock");
    check(overrun_out, 0, "no overrun");
    $display("test mode 3 erase done");
    conclude;
  end
endmodule

bind spf_front_end spf_front_end_checker chk (.clk_in, .reset_in, .sck_in, .select_n_in,
  .serial_in, .pause_n_in, .write_guard_n_in, .serial_out, .serial_out_en_out, .arr_valid_out,
  .arr_ready_in, .arr_op_out, .arr_addr_out, .arr_data_out, .arr_rvalid_in, .arr_rdata_in,
  .busy_flag_out, .write_latch_out, .block_protect_out, .status_write_lock_out, .otp_lock_out,
  .overrun_out);
